/* tsc_slave_ctrl.sv */
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
//Contract
// - Mode 111 counts selected trigger edges
// - Four-bit channel filter, 0000 means none
// - Channel polarity 0 rising, 1 falling
// - Source 110 is input two, 101 one
// - Each clock edge counts and sets flag
// - Pin inputs resynchronized to system clock
// - Ext clock enable counts trigger pin edges outside mode 111
// - Pin prescaler 00 all, 01 halves
// - Pin polarity 0 detects rising edges
// - Four-bit pin filter, 0000 means none
// - Four trigger sources: pin, one, two, other
// - Mode 110 edge sets enable and flag
// - Mode 100 edge clears counter, sets flag
// - Reset mode edge updates when source bit 0
// - Reset mode restarts count from zero
// - Mode 101 counts at level, flags transitions
// - Gated mode never counts without enable
// - Pin clock plus trigger: edge enables count
// - Capture prescaler absent from trigger path
// - Mode off counts internal clock when enabled and ext clock enable clear
module tsc_slave_ctrl
    import tsc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    input wire logic ext_trigger_pin_i,
    input wire logic timer_input_one_i,
    input wire logic timer_input_two_i,
    input wire logic itr_trigger_out_i,
    output logic [15:0] count_o,
    output logic update_event_o,
    output logic trigger_irq_o
);
    logic [3:0] slave_mode_ctrl_reg;
    logic [7:0] ext_trigger_reg;
    logic [9:0] chan_cfg_reg;
    logic urs_reg, tie_reg, counter_enable_reg;
    logic trigger_flag_reg, uif_reg;
    logic [15:0] count_reg, arr_pre_reg, arr_act_reg;
    logic trg_prev_reg, etr_prev_reg, gate_prev_reg;
    logic ti1_lvl, ti2_lvl, etr_lvl;
    logic [2:0] slave_mode_select;
    logic ece, etr_pol, trg_in, trg_edge, etr_edge, etr_tick;
    logic gate_on, cnt_tick, trig_clear, upd_now, ug_wr;
    logic tif_wr_clr, ctl_wr;

    assign slave_mode_select = slave_mode_ctrl_reg[SMS_LSB +: 3];
    assign ece = ext_trigger_reg[ECE_BIT];
    assign etr_pol = ext_trigger_reg[ETP_BIT];
    assign ctl_wr = reg_wr_i && reg_addr_i == CTL_IDX;
    assign ug_wr = ctl_wr && reg_wdata_i[UG_BIT];
    assign tif_wr_clr = reg_wr_i && reg_addr_i == STA_IDX
                        && !reg_wdata_i[TIF_BIT];

    // Synchronised, filtered inputs; the capture prescaler never sits here
    tsc_sync_filt u_ti1 (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .pin_i(timer_input_one_i),
        .filt_i(chan_cfg_reg[C1F_LSB +: 4]),
        .level_o(ti1_lvl)
    );
    tsc_sync_filt u_ti2 (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .pin_i(timer_input_two_i),
        .filt_i(chan_cfg_reg[C2F_LSB +: 4]),
        .level_o(ti2_lvl)
    );
    tsc_sync_filt u_etr (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .pin_i(ext_trigger_pin_i ^ etr_pol),
        .filt_i(ext_trigger_reg[ETF_LSB +: 4]),
        .level_o(etr_lvl)
    );
    tsc_ext_pre u_pre (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .edge_i(etr_edge),
        .div_i(ext_trigger_reg[EXT_TRIG_PRESCALE_LSB +: 2]),
        .tick_o(etr_tick)
    );

    // Trigger source select with polarity
    logic [2:0] tsf_reg;
    always_comb begin
        unique case (tsf_reg)
            TS_TI1: trg_in = ti1_lvl ^ chan_cfg_reg[C1P_BIT];
            TS_TI2: trg_in = ti2_lvl ^ chan_cfg_reg[C2P_BIT];
            TS_ETR: trg_in = etr_lvl;
            default: trg_in = itr_trigger_out_i;
        endcase
    end
    assign trg_edge = trg_in && !trg_prev_reg;
    assign etr_edge = etr_lvl && !etr_prev_reg;
    assign gate_on = slave_mode_select == SMS_GATED && trg_in && counter_enable_reg;
    assign trig_clear = slave_mode_select == SMS_RESET && trg_edge;
    assign upd_now = ug_wr || (trig_clear && !urs_reg);

    always_comb begin
        if (slave_mode_select == SMS_EXT1) begin
            cnt_tick = trg_edge;
        end else if (!counter_enable_reg) begin
            cnt_tick = 1'b0;
        end else if (slave_mode_select == SMS_GATED) begin
            cnt_tick = gate_on && (ece ? etr_tick : 1'b1);
        end else if (ece) begin
            cnt_tick = etr_tick;
        end else begin
            cnt_tick = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trg_prev_reg <= 1'b0;
            etr_prev_reg <= 1'b0;
            gate_prev_reg <= 1'b0;
        end else begin
            trg_prev_reg <= trg_in;
            etr_prev_reg <= etr_lvl;
            gate_prev_reg <= gate_on;
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            slave_mode_ctrl_reg <= 4'h0;
            tsf_reg <= TS_ITR;
            ext_trigger_reg <= 8'h00;
            chan_cfg_reg <= 10'h000;
            urs_reg <= 1'b0;
            tie_reg <= 1'b0;
            arr_pre_reg <= ARR_RESET;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                SMC_IDX: begin
                    slave_mode_ctrl_reg <= {1'b0, reg_wdata_i[SMS_LSB +: 3]};
                    tsf_reg <= reg_wdata_i[TSS_LSB +: 3];
                end
                ETC_IDX: ext_trigger_reg <= reg_wdata_i[7:0];
                CHF_IDX: chan_cfg_reg <= reg_wdata_i[9:0];
                CTL_IDX: begin
                    urs_reg <= reg_wdata_i[URS_BIT];
                    tie_reg <= reg_wdata_i[TIE_BIT];
                end
                ARR_IDX: arr_pre_reg <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // Counter enable: trigger mode edge sets it, software writes win else
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            counter_enable_reg <= 1'b0;
        end else if (slave_mode_select == SMS_TRIG && trg_edge) begin
            counter_enable_reg <= 1'b1;
        end else if (ctl_wr) begin
            counter_enable_reg <= reg_wdata_i[CEN_BIT];
        end
    end

    // Counter; a trigger reset clears it and the next cycle counts again
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_reg <= 16'h0000;
            arr_act_reg <= ARR_RESET;
            uif_reg <= 1'b0;
            update_event_o <= 1'b0;
        end else begin
            update_event_o <= upd_now;
            // Clear first so that a wrap in the same cycle sets it again
            if (reg_wr_i && reg_addr_i == STA_IDX
                && !reg_wdata_i[UIF_BIT]) begin
                uif_reg <= 1'b0;
            end
            if (upd_now) begin
                arr_act_reg <= arr_pre_reg;
            end
            if (trig_clear || ug_wr) begin
                count_reg <= 16'h0000;
            end else if (reg_wr_i && reg_addr_i == CNT_IDX) begin
                count_reg <= reg_wdata_i;
            end else if (cnt_tick) begin
                if (count_reg >= arr_act_reg) begin
                    count_reg <= 16'h0000;
                    arr_act_reg <= arr_pre_reg;
                    uif_reg <= 1'b1;
                end else begin
                    count_reg <= count_reg + 16'h0001;
                end
            end
        end
    end

    // Trigger flag: set beats the software clear
    logic tif_set;
    assign tif_set = (trg_edge && (slave_mode_select == SMS_EXT1 || slave_mode_select == SMS_TRIG
                     || slave_mode_select == SMS_RESET))
                     || (slave_mode_select == SMS_GATED && gate_on != gate_prev_reg);
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trigger_flag_reg <= 1'b0;
        end else if (tif_set) begin
            trigger_flag_reg <= 1'b1;
        end else if (tif_wr_clr) begin
            trigger_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trigger_irq_o <= 1'b0;
            count_o <= 16'h0000;
        end else begin
            trigger_irq_o <= (trigger_flag_reg || tif_set) && tie_reg;
            count_o <= count_reg;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                SMC_IDX: reg_rdata_o <= {9'h000, tsf_reg,
                                         1'b0, slave_mode_ctrl_reg[2:0]};
                ETC_IDX: reg_rdata_o <= {8'h00, ext_trigger_reg};
                CHF_IDX: reg_rdata_o <= {6'h00, chan_cfg_reg};
                CTL_IDX: reg_rdata_o <= {13'h0000, tie_reg, urs_reg,
                                         counter_enable_reg};
                STA_IDX: reg_rdata_o <= {14'h0000, uif_reg, trigger_flag_reg};
                CNT_IDX: reg_rdata_o <= count_reg;
                ARR_IDX: reg_rdata_o <= arr_pre_reg;
                default: reg_rdata_o <= 16'h0000;
            endcase
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // Assertions
    a_gate_needs_en: assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i) (slave_mode_select == SMS_GATED && !counter_enable_reg
        && !reg_wr_i) |=> count_reg == $past(count_reg))
        else $error("gated count without enable");
    a_reset_clears: assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i) (trig_clear && !ug_wr) |=> count_reg == 16'h0000)
        else $error("reset trigger did not clear");
    a_trig_starts: assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i) (slave_mode_select == SMS_TRIG && trg_edge)
        |=> counter_enable_reg)
        else $error("trigger did not start counter");
    a_flag_sets: assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i) tif_set |=> trigger_flag_reg)
        else $error("trigger flag not set");
    a_flag_sticky: assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i) (trigger_flag_reg && !tif_wr_clr)
        |=> trigger_flag_reg)
        else $error("trigger flag dropped");
    a_update_urs: assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i) (trig_clear && !urs_reg)
        |=> update_event_o)
        else $error("no update on reset trigger");
    a_irq_follows: assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i) (trigger_flag_reg && tie_reg)
        |=> trigger_irq_o)
        else $error("irq missing");
    a_internal_count: assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i) (slave_mode_select == SMS_OFF && !ece && counter_enable_reg
        && !reg_wr_i && count_reg < arr_act_reg)
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("internal clock count missing");
endmodule // tsc_slave_ctrl

/* tsc_pkg.sv */
package tsc_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] SMC_IDX = 4'h0;
    localparam logic [3:0] ETC_IDX = 4'h1;
    localparam logic [3:0] CHF_IDX = 4'h2;
    localparam logic [3:0] CTL_IDX = 4'h3;
    localparam logic [3:0] STA_IDX = 4'h4;
    localparam logic [3:0] CNT_IDX = 4'h5;
    localparam logic [3:0] ARR_IDX = 4'h6;
    // slave_mode_ctrl_reg and tsf_reg fields
    localparam int SMS_LSB = 0;
    localparam int TSS_LSB = 4;
    // ext_trigger_reg fields
    localparam int ETF_LSB = 0;
    localparam int EXT_TRIG_PRESCALE_LSB = 4;
    localparam int ETP_BIT = 6;
    localparam int ECE_BIT = 7;
    // Channel filter / polarity register fields
    localparam int C1F_LSB = 0;
    localparam int C2F_LSB = 4;
    localparam int C1P_BIT = 8;
    localparam int C2P_BIT = 9;
    // Control register bits
    localparam int CEN_BIT = 0;
    localparam int URS_BIT = 1;
    localparam int TIE_BIT = 2;
    localparam int UG_BIT = 3;
    // Status register bits
    localparam int TIF_BIT = 0;
    localparam int UIF_BIT = 1;
    // Mode, source, filter, prescaler and reload reset codes
    localparam logic [2:0] SMS_OFF = 3'h0;
    localparam logic [2:0] SMS_RESET = 3'h4;
    localparam logic [2:0] SMS_GATED = 3'h5;
    localparam logic [2:0] SMS_TRIG = 3'h6;
    localparam logic [2:0] SMS_EXT1 = 3'h7;
    localparam logic [2:0] TS_ITR = 3'h0;
    localparam logic [2:0] TS_TI1 = 3'h5;
    localparam logic [2:0] TS_TI2 = 3'h6;
    localparam logic [2:0] TS_ETR = 3'h7;
    localparam logic [3:0] FILT_NONE = 4'h0;
    localparam logic [1:0] EXT_TRIG_PRESCALE_DIV1 = 2'h0;
    localparam logic [1:0] EXT_TRIG_PRESCALE_DIV2 = 2'h1;
    localparam logic [1:0] EXT_TRIG_PRESCALE_DIV4 = 2'h2;
    localparam logic [15:0] ARR_RESET = 16'hffff;
endpackage

/* tsc_sync_filt.sv */
`timescale 1ns/100ps
module tsc_sync_filt
    import tsc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic pin_i,
    input wire logic [3:0] filt_i,
    output logic level_o
);
    logic s1_reg, s2_reg, s3_reg;
    logic [4:0] run_reg;
    // Three stages; a change is taken only when stages 2 and 3 agree
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    // Filter: input must hold for filt_i + 1 agreeing samples before passing
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            run_reg <= 5'h00;
            level_o <= 1'b0;
        end else if (s2_reg != s3_reg || s3_reg == level_o) begin
            run_reg <= 5'h00;
        end else if (filt_i == FILT_NONE
                     || run_reg >= {1'b0, filt_i}) begin
            level_o <= s3_reg;
            run_reg <= 5'h00;
        end else begin
            run_reg <= run_reg + 5'h01;
        end
    end
endmodule // tsc_sync_filt

/* tsc_ext_pre.sv */
`timescale 1ns/100ps
module tsc_ext_pre
    import tsc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic edge_i,
    input wire logic [1:0] div_i,
    output logic tick_o
);
    logic [2:0] cnt_reg;
    logic [2:0] lim;
    always_comb begin
        unique case (div_i)
            EXT_TRIG_PRESCALE_DIV1: lim = 3'h0;
            EXT_TRIG_PRESCALE_DIV2: lim = 3'h1;
            EXT_TRIG_PRESCALE_DIV4: lim = 3'h3;
            default: lim = 3'h7;
        endcase
    end
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_reg <= 3'h0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (edge_i) begin
                if (cnt_reg >= lim) begin
                    cnt_reg <= 3'h0;
                    tick_o <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 3'h1;
                end
            end
        end
    end
endmodule // tsc_ext_pre

/* tsc_pin_src.sv */
`timescale 1ns/100ps
module tsc_pin_src
    import tsc_pkg::*;
#(
    parameter int LAG = 2
)(
    input wire logic core_clk_i,
    input wire logic [3:0] lvl_i,
    output logic ext_trigger_pin_o,
    output logic timer_input_one_o,
    output logic timer_input_two_o,
    output logic itr_trigger_out_o
);
    logic [3:0] pipe_reg [LAG];

    always_ff @(posedge core_clk_i) begin
        pipe_reg[0] <= lvl_i;
        for (int i = 1; i < LAG; i++) begin
            pipe_reg[i] <= pipe_reg[i-1];
        end
    end

    // Pins move mid-cycle so the resync path meets truly async edges
    assign #13 ext_trigger_pin_o = pipe_reg[LAG-1][0];
    assign #13 timer_input_one_o = pipe_reg[LAG-1][1];
    assign #13 timer_input_two_o = pipe_reg[LAG-1][2];
    // Other timer shares our clock, so its output follows the edge
    assign itr_trigger_out_o = pipe_reg[LAG-1][3];
endmodule // tsc_pin_src

/* tsc_slave_ctrl_tb.sv */
`timescale 1ns/100ps
module tsc_slave_ctrl_tb
    import tsc_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [15:0] reg_rdata_o;
    logic [3:0] lvl = 4'h0;
    logic pin_etr, pin_one, pin_two, pin_itr;
    logic [15:0] count_o;
    logic update_event_o;
    logic trigger_irq_o;
    logic [15:0] rd_val;
    logic [15:0] snap;
    int n_mismatch = 0;
    int samples_checked = 0;
    int n_upd = 0;
    int upd_base = 0;

    initial forever #20 core_clk_i = ~core_clk_i;
    initial begin
        repeat (20) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
    end
    always @(posedge core_clk_i) begin
        if (update_event_o === 1'b1) n_upd <= n_upd + 1;
    end

    tsc_pin_src u_tsc_pin_src (.core_clk_i(core_clk_i), .lvl_i(lvl),
        .ext_trigger_pin_o(pin_etr), .timer_input_one_o(pin_one),
        .timer_input_two_o(pin_two), .itr_trigger_out_o(pin_itr));
    tsc_slave_ctrl u_tsc_slave_ctrl (.core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .ext_trigger_pin_i(pin_etr), .timer_input_one_i(pin_one),
        .timer_input_two_i(pin_two), .itr_trigger_out_i(pin_itr),
        .count_o(count_o), .update_event_o(update_event_o),
        .trigger_irq_o(trigger_irq_o));

    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("wrong value at %0t ns: %s", $time, msg);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 rd_val = reg_rdata_o;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    // Gap after each pulse keeps the line quiet long enough for the filter settings used here
    task automatic pulse(input int k, input int w);
        @(posedge core_clk_i);
        lvl[k] <= 1'b1;
        repeat (w) @(posedge core_clk_i);
        lvl[k] <= 1'b0;
        idle(12);
    endtask

    task automatic t_regs;
        rd(ARR_IDX);
        chk(rd_val === ARR_RESET, "reload reset value");
        wr(4'h9, 16'h1234);
        rd(4'h9);
        chk(rd_val === 16'h0000, "unmapped read");
        chk(count_o === 16'h0000, "count while disabled");
        wr(CTL_IDX, 16'h0001);
        idle(5);
        snap = count_o;
        idle(10);
        chk((count_o - snap) === 16'h000a, "internal clock rate");
        $display("regs done");
    endtask
    task automatic t_ext1;
        wr(CHF_IDX, 16'h0080);
        wr(SMC_IDX, {9'h000, TS_TI2, 1'b0, SMS_EXT1});
        wr(CTL_IDX, 16'h000c);
        pulse(2, 3);
        chk(count_o === 16'h0000, "glitch passed filter");
        for (int i = 0; i < 3; i++) pulse(2, 12);
        chk(count_o === 16'h0003, "edge count");
        chk(trigger_irq_o === 1'b1, "irq after edge");
        wr(STA_IDX, 16'h0000);
        idle(3);
        chk(trigger_irq_o === 1'b0, "irq after clear");
        $display("ext clock one done");
    endtask
    task automatic t_ext2;
        for (int p = 0; p < 2; p++) begin
            wr(SMC_IDX, 16'h0000);
            wr(CTL_IDX, 16'h0008);
            wr(ETC_IDX, {8'h00, 2'b10, p[0] ? EXT_TRIG_PRESCALE_DIV2 : EXT_TRIG_PRESCALE_DIV1,
                FILT_NONE});
            wr(CTL_IDX, 16'h0001);
            for (int i = 0; i < 4; i++) pulse(0, 6);
            chk(count_o === (p[0] ? 16'h0002 : 16'h0004),
                "pin clock count");
        end
        wr(CTL_IDX, 16'h0008);
        wr(ETC_IDX, 16'h0080);
        wr(SMC_IDX, {9'h000, TS_TI1, 1'b0, SMS_TRIG});
        pulse(0, 6);
        chk(count_o === 16'h0000, "pin clock before trigger");
        pulse(1, 6);
        pulse(0, 6);
        pulse(0, 6);
        chk(count_o === 16'h0002, "pin clock after trigger");
        wr(ETC_IDX, 16'h0000);
        $display("ext clock two done");
    endtask
    task automatic t_trig;
        logic [2:0] srcs [4] = '{TS_ITR, TS_TI1, TS_TI2, TS_ETR};
        int lines [4] = '{3, 1, 2, 0};
        wr(CHF_IDX, 16'h0000);
        for (int s = 0; s < 4; s++) begin
            wr(CTL_IDX, 16'h0008);
            wr(STA_IDX, 16'h0000);
            wr(SMC_IDX, {9'h000, srcs[s], 1'b0, SMS_TRIG});
            idle(10);
            chk(count_o === 16'h0000, "count before start");
            pulse(lines[s], 6);
            chk(count_o > 16'h0000, "count after start");
            rd(CTL_IDX);
            chk(rd_val[CEN_BIT] === 1'b1, "enable by trigger");
            rd(STA_IDX);
            chk(rd_val[TIF_BIT] === 1'b1, "flag on start");
        end
        $display("trigger start done");
    endtask
    task automatic t_rst;
        for (int u = 0; u < 2; u++) begin
            wr(CTL_IDX, 16'h0008);
            wr(STA_IDX, 16'h0000);
            wr(SMC_IDX, {9'h000, TS_TI1, 1'b0, SMS_RESET});
            wr(CTL_IDX, u[0] ? 16'h0003 : 16'h0001);
            idle(60);
            chk(count_o > 16'h0030, "running before trigger");
            upd_base = n_upd;
            pulse(1, 6);
            chk(count_o < 16'h0019, "restart from zero");
            chk(n_upd - upd_base == (u ? 0 : 1), "update on trigger");
            rd(STA_IDX);
            chk(rd_val[TIF_BIT] === 1'b1, "flag on reset");
        end
        $display("trigger reset done");
    endtask
    task automatic t_gate;
        wr(CTL_IDX, 16'h0008);
        wr(CHF_IDX, 16'h0100);
        wr(SMC_IDX, {9'h000, TS_TI1, 1'b0, SMS_GATED});
        idle(20);
        chk(count_o === 16'h0000, "gated without enable");
        wr(CTL_IDX, 16'h0001);
        idle(20);
        chk(count_o > 16'h000a, "count at low level");
        wr(STA_IDX, 16'h0000);
        @(posedge core_clk_i);
        lvl[1] <= 1'b1;
        idle(12);
        snap = count_o;
        idle(20);
        chk(count_o === snap, "count stops at high");
        rd(STA_IDX);
        chk(rd_val[TIF_BIT] === 1'b1, "flag on stop");
        @(posedge core_clk_i);
        lvl[1] <= 1'b0;
        $display("gated done");
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk_i);
        n_mismatch++;
        $display("wrong value at %0t ns: run hung", $time);
        give_verdict;
    end
    initial begin
        @(posedge rst_b_i);
        t_regs;
        t_ext1;
        t_ext2;
        t_trig;
        t_rst;
        t_gate;
        give_verdict;
    end
endmodule // tsc_slave_ctrl_tb
